//--- logic/crms_pkg.sv
/*
 Shared constants, types and helper functions of the readout mode sequencer.
 Assumes all counts are in horizontal line periods delivered by the timing generator.
*/
package crms_pkg;

	localparam int LW         = 11;  // line and row counter width
	localparam int PW         = 12;  // sensor pixel width
	localparam int SW         = 13;  // pixel pair sum width
	localparam int FIFO_DEPTH = 16;

	// line geometry
	localparam logic [LW-1:0] FIELD_LINES = 11'h307;  // 775 per field
	localparam logic [LW-1:0] FAST_LINES  = 11'h102;  // 258 per fast frame
	localparam logic [LW-1:0] GROUP_ROWS  = 11'h00c;  // 12 rows per group
	localparam logic [LW-1:0] GROUP_READ  = 11'h004;  // 4 rows read per group
	localparam logic [LW-1:0] ONE         = 11'h001;

	// focus window geometry
	localparam logic [LW-1:0] START_FAST_H    = 11'h01a;  // 26H
	localparam logic [LW-1:0] START_FASTEST_H = 11'h01e;  // 30H
	localparam logic [LW-1:0] FIRST_OFS       = 11'h003;  // i+3
	localparam logic [LW-1:0] END_FAST_NTSC   = 11'h06c;  // i+108
	localparam logic [LW-1:0] END_FAST_PAL    = 11'h086;  // i+134
	localparam logic [LW-1:0] END_FSTST_NTSC  = 11'h026;  // i+38
	localparam logic [LW-1:0] END_FSTST_PAL   = 11'h033;  // i+51

	// frame lengths in line periods
	localparam logic [LW-1:0] FLEN_FAST_NTSC  = 11'h107;  // 263H, 1/60s
	localparam logic [LW-1:0] FLEN_FAST_PAL   = 11'h13b;  // 315H, 1/50s
	localparam logic [LW-1:0] FLEN_FSTST_NTSC = 11'h084;  // 132H, 1/120s
	localparam logic [LW-1:0] FLEN_FSTST_PAL  = 11'h09e;  // 158H, 1/100s

	typedef enum logic [1:0] {
		MODE_FRAME,
		MODE_FAST,
		MODE_FOCUS_FAST,
		MODE_FOCUS_FASTEST
	} crms_mode_e;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FIELD_A,
		ST_FIELD_B,
		ST_RUN
	} crms_state_e;

	typedef struct packed {
		crms_mode_e mode;
		logic       pal;    // 625-line timing when set
		logic [7:0] shift;  // frame-shift line count i
	} crms_cfg_s;

	typedef struct packed {
		logic          field;  // 0 first field, 1 second field
		logic [LW-1:0] line;
		logic [LW-1:0] row;
		logic [SW-1:0] data;
	} crms_word_s;

	typedef struct packed {
		crms_state_e   st;
		crms_cfg_s     cfg;
		logic [LW-1:0] hcnt;
		logic [LW-1:0] lnum;
		logic [LW-1:0] row;
		logic          active;
		logic          have_half;
		logic [PW-1:0] half;
		logic          done;
	} crms_seq_s;

	// sensor row of fast-mode line k (1-based): 4 consecutive rows of every 12
	function automatic logic [LW-1:0] fast_row(input logic [LW-1:0] k);
		logic [LW-1:0] kk;
		kk = k - ONE;
		fast_row = LW'((kk >> 2) * GROUP_ROWS + {9'h000, kk[1:0]});
	endfunction

endpackage

//--- logic/crms_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides, flip-flop storage.
 Assumes DEPTH is a power of two and a single clock with active-low async reset.
*/
`timescale 1ns/1ps
module crms_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr;
		logic [AW-1:0]           rd;
		logic [AW:0]             cnt;
	} crms_fifo_s;

	crms_fifo_s s_q;
	crms_fifo_s s_d;
	logic       wr_en;
	logic       rd_en;

	// honest flags straight from the occupancy count
	assign in_ready  = s_q.cnt != FULL;
	assign out_valid = s_q.cnt != '0;
	assign out_data  = s_q.mem[s_q.rd];
	assign wr_en     = in_valid && in_ready;
	assign rd_en     = out_valid && out_ready;

	// pointer and count update; simultaneous push and pop keep the count
	always_comb begin
		s_d = s_q;
		if (wr_en) begin
			s_d.mem[s_q.wr] = in_data;
			s_d.wr = s_q.wr + AW'(1);
		end
		if (rd_en) begin
			s_d.rd = s_q.rd + AW'(1);
		end
		s_d.cnt = s_q.cnt + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

//--- logic/crms_sequencer.sv
/*
 Readout mode line sequencer: tags each line period of the selected readout mode,
 passes or pair-adds pixels and queues tagged words in a 16-word FIFO.
 Assumes FRAME_START, LINE_TICK, CFG and the pixel stream come from timing logic on MCLK.
*/
// Functional notes
// - Frame readout passes every pixel on its own, the image split over two fields.
// - Fast readout reads only 4 rows of each group of 12, in a frame of 259 line periods, about 1/60s.
// - Fast readout and its derived modes sum each pair of adjacent pixels before output.
// - Fast readout outputs 258 effective lines per frame.
// - The first focus mode gives a frame each 1/60s at 525 lines and 1/50s at 625 lines.
// - The second focus mode gives a frame each 1/120s at 525 lines and 1/100s at 625 lines.
// - Window output starts at line period 26H in the first focus mode and 30H in the second.
// - The window never passes fast line 258, so it is cut short for large counts.
// - In frame readout the first line type lies in the first field, the second in the second.
// - Frame readout gives 1550 lines per frame, 775 in each field.
`timescale 1ns/1ps
module crms_sequencer
	import crms_pkg::*;
(
	input  wire logic          MCLK,
	input  wire logic          RSTN,
	input  wire crms_cfg_s     CFG,
	input  wire logic          FRAME_START,
	input  wire logic          LINE_TICK,
	input  wire logic          PIX_VALID,
	output logic               PIX_READY,
	input  wire logic [PW-1:0] PIX_DATA,
	output logic               OUT_VALID,
	input  wire logic          OUT_READY,
	output crms_word_s         OUT_DATA,
	output logic               BUSY,
	output logic               LINE_ACTIVE,
	output logic               FRAME_DONE
);
	crms_seq_s     s_q;
	crms_seq_s     s_d;
	crms_word_s    wdata;
	logic          push;
	logic          fifo_rdy;
	logic          pair;
	logic          focus;
	logic [LW-1:0] h;
	logic [LW-1:0] shift_ext;
	logic [LW-1:0] win_start;
	logic [LW-1:0] win_first;
	logic [LW-1:0] win_last;
	logic [LW-1:0] last_raw;
	logic [LW-1:0] flen;

	// decoded view of the latched configuration
	assign pair      = s_q.cfg.mode != MODE_FRAME;
	assign focus     = s_q.cfg.mode == MODE_FOCUS_FAST || s_q.cfg.mode == MODE_FOCUS_FASTEST;
	assign h         = s_q.hcnt + ONE;
	assign shift_ext = {3'h0, s_q.cfg.shift};

	// window geometry per mode; plain fast mode is a window over all 258 lines
	always_comb begin
		win_start = ONE;
		win_first = ONE;
		last_raw  = FAST_LINES;
		flen      = FAST_LINES + ONE;
		unique case (s_q.cfg.mode)
		MODE_FRAME, MODE_FAST: begin
		end
		MODE_FOCUS_FAST: begin
			win_start = START_FAST_H;
			win_first = shift_ext + FIRST_OFS;
			last_raw  = shift_ext + (s_q.cfg.pal ? END_FAST_PAL : END_FAST_NTSC);
			flen      = s_q.cfg.pal ? FLEN_FAST_PAL : FLEN_FAST_NTSC;
		end
		MODE_FOCUS_FASTEST: begin
			win_start = START_FASTEST_H;
			win_first = shift_ext + FIRST_OFS;
			last_raw  = shift_ext + (s_q.cfg.pal ? END_FSTST_PAL : END_FSTST_NTSC);
			flen      = s_q.cfg.pal ? FLEN_FSTST_PAL : FLEN_FSTST_NTSC;
		end
		endcase
		// a large shift count cuts the window at the last fast line
		win_last = (last_raw > FAST_LINES) ? FAST_LINES : last_raw;
	end

	// pixel path first, then line sequencing, so a line tick drops a stray half pair
	always_comb begin
		s_d        = s_q;
		s_d.done   = 1'b0;
		push       = 1'b0;
		wdata      = '0;
		wdata.field = s_q.st == ST_FIELD_B;
		wdata.line = s_q.lnum;
		wdata.row  = s_q.row;
		if (PIX_VALID && fifo_rdy && s_q.active) begin
			if (!pair) begin
				push = 1'b1;
				wdata.data = {1'b0, PIX_DATA};
			end else if (!s_q.have_half) begin
				s_d.half = PIX_DATA;
				s_d.have_half = 1'b1;
			end else begin
				push = 1'b1;
				s_d.have_half = 1'b0;
				wdata.data = {1'b0, s_q.half} + {1'b0, PIX_DATA};
			end
		end
		if (FRAME_START) begin
			// configuration is sampled only here and held to the frame end
			s_d.cfg = CFG;
			s_d.hcnt = '0;
			s_d.lnum = '0;
			s_d.row = '0;
			s_d.active = 1'b0;
			s_d.have_half = 1'b0;
			s_d.st = (CFG.mode == MODE_FRAME) ? ST_FIELD_A : ST_RUN;
		end else if (LINE_TICK) begin
			s_d.have_half = 1'b0;
			unique case (s_q.st)
			ST_IDLE: begin
			end
			ST_FIELD_A, ST_FIELD_B: begin
				if (s_q.lnum == FIELD_LINES) begin
					s_d.lnum = ONE;
					s_d.row = ONE;
					s_d.active = s_q.st == ST_FIELD_A;
					s_d.st = (s_q.st == ST_FIELD_A) ? ST_FIELD_B : ST_IDLE;
					s_d.done = s_q.st == ST_FIELD_B;
				end else begin
					s_d.lnum = s_q.lnum + ONE;
					s_d.active = 1'b1;
					// even rows in the first field, odd rows in the second
					s_d.row = {s_q.lnum[9:0], s_q.st == ST_FIELD_B};
				end
			end
			ST_RUN: begin
				s_d.hcnt = h;
				if (h == win_start) begin
					s_d.active = 1'b1;
					s_d.lnum = win_first;
				end else if (s_q.active && s_q.lnum < win_last) begin
					s_d.lnum = s_q.lnum + ONE;
				end else begin
					s_d.active = 1'b0;
				end
				s_d.row = fast_row(s_d.lnum);
				if (h == flen) begin
					s_d.st = ST_IDLE;
					s_d.active = 1'b0;
					s_d.done = 1'b1;
				end
			end
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// output queue; a stalled reader stalls the pixel source through PIX_READY
	crms_fifo #(
		.W     ($bits(crms_word_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (MCLK),
		.rst_n     (RSTN),
		.in_valid  (push),
		.in_ready  (fifo_rdy),
		.in_data   (wdata),
		.out_valid (OUT_VALID),
		.out_ready (OUT_READY),
		.out_data  (OUT_DATA)
	);

	// status outputs straight from state flops
	assign PIX_READY   = fifo_rdy;
	assign BUSY        = s_q.st != ST_IDLE;
	assign LINE_ACTIVE = s_q.active;
	assign FRAME_DONE  = s_q.done;

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);

	// first field closes after 775 lines
	field_switch_a: assert property (
		s_q.st == ST_FIELD_A && LINE_TICK && !FRAME_START && s_q.lnum == FIELD_LINES
		|=> s_q.st == ST_FIELD_B && s_q.lnum == ONE && s_q.active)
		else $error("first field did not hand over after 775 lines");

	// every pixel taken on an output line in frame readout is queued unchanged
	frame_pass_a: assert property (
		PIX_VALID && PIX_READY && LINE_ACTIVE && !pair |-> push && wdata.data == {1'b0, PIX_DATA})
		else $error("frame readout pixel altered or lost");

	// row parity matches field
	frame_parity_a: assert property (
		push && !pair |-> wdata.row[0] == wdata.field)
		else $error("row landed in the wrong field");

	// second pixel of a pair is queued as the sum with the held half
	pair_sum_a: assert property (
		PIX_VALID && PIX_READY && LINE_ACTIVE && pair && s_q.have_half
		|-> push && wdata.data == {1'b0, s_q.half} + {1'b0, PIX_DATA})
		else $error("pixel pair not summed");

	// fast frame ends after line 258
	fast_end_a: assert property (
		s_q.st == ST_RUN && s_q.cfg.mode == MODE_FAST && LINE_TICK && !FRAME_START
		&& s_q.active && s_q.lnum == FAST_LINES |=> !s_q.active && s_q.st == ST_IDLE && FRAME_DONE)
		else $error("fast frame did not end after line 258");

	// window bounded by the fast frame
	line_cap_a: assert property (
		s_q.active && pair |-> s_q.lnum <= FAST_LINES && s_q.lnum >= ONE)
		else $error("fast line number out of range");

	// only 4 rows of 12 reach the output
	decimate_a: assert property (
		s_q.active && pair |-> (s_q.row % GROUP_ROWS) < GROUP_READ)
		else $error("row outside the decimation pattern");

	// window opens at its start period with line i+3
	win_start_a: assert property (
		s_q.st == ST_RUN && focus && LINE_TICK && !FRAME_START && h == win_start
		|=> s_q.active && s_q.lnum == {3'h0, $past(s_q.cfg.shift)} + FIRST_OFS)
		else $error("focus window opened wrongly");

	// focus frame length sets the frame rate
	frame_len_a: assert property (
		s_q.st == ST_RUN && focus && LINE_TICK && !FRAME_START && h == flen
		|=> FRAME_DONE && !BUSY ##1 !FRAME_DONE)
		else $error("focus frame length wrong");

	// configuration held between frame starts
	cfg_hold_a: assert property (
		!FRAME_START |=> s_q.cfg == $past(s_q.cfg))
		else $error("configuration changed inside a frame");
endmodule

//--- bench/crms_partner.sv
/*
 Timing generator model: frame start pulse, line ticks PER cycles apart, held configuration.
 Assumes one MCLK domain and one GO pulse from the bench for each frame.
*/
`timescale 1ns/1ps
module crms_partner
	import crms_pkg::*;
#(
	parameter int PER = 8
) (
	input  wire logic        MCLK,
	input  wire logic        RSTN,
	input  wire logic        GO,
	input  wire crms_cfg_s   CFG_IN,
	input  wire logic [15:0] NTICKS,
	output crms_cfg_s        CFG,
	output logic             FRAME_START,
	output logic             LINE_TICK,
	output logic             IDLE
);
	logic [15:0] left;
	logic [7:0]  cnt;

	// config only moves at a frame start, so the window never shifts mid-frame
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			CFG <= '0;
			FRAME_START <= 1'b0;
			LINE_TICK <= 1'b0;
			IDLE <= 1'b1;
			left <= 16'h0000;
			cnt <= 8'h00;
		end else begin
			FRAME_START <= 1'b0;
			LINE_TICK <= 1'b0;
			if (GO) begin
				CFG <= CFG_IN;
				FRAME_START <= 1'b1;
				left <= NTICKS;
				cnt <= 8'(PER);
				IDLE <= 1'b0;
			end else if (!IDLE) begin
				if (cnt == 8'h01) begin
					cnt <= 8'(PER);
					if (left == 16'h0000) begin
						IDLE <= 1'b1;
					end else begin
						LINE_TICK <= 1'b1;
						left <= left - 16'h0001;
					end
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
		end
	end
endmodule

//--- bench/crms_sequencer_bench.sv
/*
 Self-checking bench of the readout mode sequencer, timing generator model on the far side.
 Assumes ticks 8 cycles apart, so two pixels of a line always fit before the next tick.
*/
`timescale 1ns/1ps
module crms_sequencer_bench
	import crms_pkg::*;
;
	logic          MCLK, RSTN, PIX_VALID, OUT_READY, go, FRAME_START, LINE_TICK, idle;
	logic          PIX_READY, OUT_VALID, BUSY, LINE_ACTIVE, FRAME_DONE, stall_scn;
	logic [PW-1:0] PIX_DATA;
	crms_cfg_s     cfg_in, CFG;
	crms_word_s    OUT_DATA;
	logic [15:0]   nt;
	logic [35:0]   q[$];
	int            h, n_done, n_mismatch, check_count, rmode;
	logic [31:0]   p_lfsr = 32'h61a1, r_lfsr = 32'h61a1;
	crms_cfg_s     sc[6] = '{'{MODE_FRAME, 1'b0, 8'h00}, '{MODE_FAST, 1'b0, 8'h00},
		'{MODE_FOCUS_FAST, 1'b0, 8'h64}, '{MODE_FOCUS_FAST, 1'b1, 8'ha0},
		'{MODE_FOCUS_FASTEST, 1'b0, 8'h00}, '{MODE_FOCUS_FASTEST, 1'b1, 8'hff}};
	logic [15:0]   snt[6] = '{16'h060f, 16'h0103, 16'h0107, 16'h013b, 16'h0084, 16'h009e};

	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	initial begin
		MCLK = 1'b0;
		forever #2.5 MCLK = ~MCLK;
	end

	crms_sequencer dut_u (.MCLK(MCLK), .RSTN(RSTN), .CFG(CFG), .FRAME_START(FRAME_START),
		.LINE_TICK(LINE_TICK), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIX_DATA(PIX_DATA),
		.OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .BUSY(BUSY),
		.LINE_ACTIVE(LINE_ACTIVE), .FRAME_DONE(FRAME_DONE));
	crms_partner #(.PER(8)) gen_u (.MCLK(MCLK), .RSTN(RSTN), .GO(go), .CFG_IN(cfg_in), .NTICKS(nt),
		.CFG(CFG), .FRAME_START(FRAME_START), .LINE_TICK(LINE_TICK), .IDLE(idle));

	task chk(input logic [35:0] got, input logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// hold the pixel until the edge that takes it
	task send(input logic [PW-1:0] d);
		PIX_DATA <= d;
		PIX_VALID <= 1'b1;
		do @(posedge MCLK); while (PIX_READY !== 1'b1);
	endtask

	task tally_and_finish;
		if (n_mismatch == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// per line: predict line, row, field and activity, then feed two pixels on an active line
	always begin
		logic          act, fld;
		logic [10:0]   ln, rw;
		logic [PW-1:0] d0, d1;
		int            hs, e;
		do @(posedge MCLK); while (LINE_TICK !== 1'b1);
		h = h + 1;
		chk(BUSY, 1'b1);
		act = 1'b0;
		fld = 1'b0;
		ln = 11'(h);
		rw = 11'h000;
		case (cfg_in.mode)
			MODE_FRAME: begin
				act = h <= 1550;
				fld = h > 775;
				if (fld) ln = 11'(h - 775);
				rw = 11'(2 * ln - 2 + fld);
			end
			MODE_FAST: act = h <= 258;
			default: begin
				hs = cfg_in.mode == MODE_FOCUS_FAST ? 26 : 30;
				e = cfg_in.mode == MODE_FOCUS_FAST ? (cfg_in.pal ? 134 : 108) : (cfg_in.pal ? 51 : 38);
				ln = 11'(cfg_in.shift + 3 + h - hs);
				act = h >= hs && ln <= cfg_in.shift + e && ln <= 258;
			end
		endcase
		if (cfg_in.mode != MODE_FRAME) rw = 11'((ln - 1) / 4 * 12 + (ln - 1) % 4);
		if (stall_scn) rmode = h <= 8 ? 1 : (h <= 12 ? 2 : 0);
		if (stall_scn && h == 9) chk(PIX_READY, 1'b0);
		@(posedge MCLK);
		chk(LINE_ACTIVE, act);
		if (act) begin
			p_lfsr = nxt(p_lfsr);
			d0 = p_lfsr[11:0];
			p_lfsr = nxt(p_lfsr);
			d1 = p_lfsr[11:0];
			if (cfg_in.mode == MODE_FRAME) begin
				q.push_back({fld, ln, rw, 1'b0, d0});
				q.push_back({fld, ln, rw, 1'b0, d1});
			end else begin
				q.push_back({1'b0, ln, rw, 13'(d0) + 13'(d1)});
			end
			send(d0);
			send(d1);
			PIX_VALID <= 1'b0;
		end
	end

	// far side drains at random, or stalls long enough to fill the fifo
	always @(posedge MCLK) begin
		r_lfsr = nxt(r_lfsr);
		OUT_READY <= rmode == 1 ? 1'b0 : (rmode == 2 ? 1'b1 : r_lfsr[0]);
	end

	// oldest note against each popped word; frame end against tick count
	always @(posedge MCLK) begin
		// a word with no note is a mismatch even when the word is unknown
		if (OUT_VALID === 1'b1 && OUT_READY === 1'b1) begin
			if (q.size() == 0) chk(36'h0, 36'h1);
			else chk(OUT_DATA, q.pop_front());
		end
		if (FRAME_DONE === 1'b1) begin
			n_done++;
			chk(36'(h), 36'(nt));
		end
	end

	// watchdog sized well above the six frames
	initial begin
		repeat (60000) @(posedge MCLK);
		n_mismatch++;
		tally_and_finish;
	end

	initial begin
		RSTN = 1'b0;
		PIX_VALID = 1'b0;
		PIX_DATA = '0;
		OUT_READY = 1'b0;
		go = 1'b0;
		cfg_in = '0;
		nt = 16'h0000;
		{h, n_done, n_mismatch, check_count, rmode} = '0;
		stall_scn = 1'b0;
		repeat (3) @(posedge MCLK);
		RSTN <= 1'b1;
		for (int s = 0; s < 6; s++) begin
			cfg_in <= sc[s];
			nt <= snt[s];
			stall_scn = s == 0;
			h = 0;
			go <= 1'b1;
			@(posedge MCLK);
			go <= 1'b0;
			repeat (2) @(posedge MCLK);
			for (int k = 0; k < 20000 && idle !== 1'b1; k++) @(posedge MCLK);
			// a generator that never goes idle ran out the wait limit
			chk(idle, 1'b1);
			repeat (40) @(posedge MCLK);
			chk(BUSY, 1'b0);
			chk(OUT_VALID, 1'b0);
			chk(36'(q.size()), 36'h0);
			chk(36'(n_done), 36'(s + 1));
		end
		tally_and_finish;
	end
endmodule
